/* File: bench/sfel_sequencer_checker.sv */
// Checker for the erase and write-enable sequencer, bound to its ports.
// Assumes the SPI frames end with chip select high for several clocks.
`timescale 1ns/1ps
module sfel_sequencer_checker (
  input wire clk_in, // Clock
  input wire arst_n_in, // Reset, active low
  input wire spi_cs_n_in, // Chip select
  input wire array_protect_bit_in, // Protect level
  input wire write_enable_latch_out, // Latch
  input wire busy_out, // Busy flag
  input wire erase_program_error_flag_out, // Error flag
  input wire erase_start_out, // Start pulse
  input wire [2:0] erase_kind_out, // Erase kind
  input wire erase_done_out // Done pulse
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence start_s;
    erase_start_out;
  endsequence
  sequence hold_s;
    (busy_out && !erase_done_out)[*8];
  endsequence
  start_busy_a: assert property (start_s |-> hold_s)
    else $error("busy not held after erase start");
  wel_clear_a: assert property (start_s |=> !write_enable_latch_out)
    else $error("latch not cleared after erase start");
  wel_needed_a: assert property (start_s |->
    $past(write_enable_latch_out))
    else $error("erase started without latch");
  protect_a: assert property (start_s |-> !array_protect_bit_in)
    else $error("erase started on protected array");
  kind_ok_a: assert property (start_s |->
    erase_kind_out inside {[1:4]})
    else $error("bad erase kind at start");
  done_idle_a: assert property (erase_done_out |=> !busy_out)
    else $error("busy after erase done");
  flag_time_a: assert property ($changed(erase_program_error_flag_out)
    |-> erase_done_out || busy_out)
    else $error("error flag changed outside erase");
  wel_quiet_a: assert property ($changed(write_enable_latch_out)
    |-> spi_cs_n_in)
    else $error("latch changed inside a frame");
  wel_idle_a: assert property ($rose(write_enable_latch_out)
    |-> !busy_out)
    else $error("latch set while busy");
endmodule

bind sfel_sequencer sfel_sequencer_checker chk (
  .clk_in(clk_in),
  .arst_n_in(arst_n_in),
  .spi_cs_n_in(spi_cs_n_in),
  .array_protect_bit_in(array_protect_bit_in),
  .write_enable_latch_out(write_enable_latch_out),
  .busy_out(busy_out),
  .erase_program_error_flag_out(erase_program_error_flag_out),
  .erase_start_out(erase_start_out),
  .erase_kind_out(erase_kind_out),
  .erase_done_out(erase_done_out)
);

/* File: bench/sfel_spi_host.sv */
// SPI host model, modes 0 and 3, 125 ns clock, MSB first.
// Assumes one frame at a time is requested through the frame task.
`timescale 1ns/1ps
module sfel_spi_host (
  output logic cs_n_out, // Chip select, active low
  output logic sck_out, // Serial clock, still between frames
  output logic si_out // Serial data
);
  initial
  begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
  end
  // Sends n bits of d from the top; n chooses truncated or unaligned ends
  task automatic frame(input logic [39:0] d, input int n, input bit mode3);
    // Off the clock edges; idle clock level is set before selecting
    #1.25 sck_out = mode3;
    #40 cs_n_out = 1'b0;
    #40;
    for (int i = 0; i < n; i++)
    begin
      if (mode3)
        #62.5 sck_out = 1'b0;
      si_out = d[39-i];
      #62.5 sck_out = 1'b1;
      if (!mode3)
        #62.5 sck_out = 1'b0;
    end
    #40 cs_n_out = 1'b1;
    si_out = ~si_out;
    #250;
  endtask
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the erase and write-enable sequencer.
// Assumes erase counts of about a hundred clocks, so erases end quickly.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %0t: got %0h expected %0h", $time, g, e); end end
module tb_top;
  logic clk_in = 0, arst_n_in = 0, array_protect_bit_in = 0;
  logic erase_fail_in = 0;
  wire spi_cs_n_in, spi_sck_in, spi_si_in, write_enable_latch_out;
  wire busy_out, erase_program_error_flag_out, erase_start_out;
  wire erase_done_out;
  wire [2:0] erase_kind_out;
  wire [7:0] page_select_bits_out;
  wire [8:0] block_select_out;
  int fails = 0, checks_done = 0, cycles = 0, seed = 10;
  bit m_wel = 0, mode3 = 0;
  logic [7:0] ops [7] = '{8'h81, 8'h20, 8'h52, 8'hD8, 8'h60, 8'h62, 8'hC7};
  always #2 clk_in = ~clk_in;
  sfel_spi_host host (.cs_n_out(spi_cs_n_in), .sck_out(spi_sck_in),
    .si_out(spi_si_in));
  sfel_sequencer #(.PAGE_ERASE_CYCLES(100), .BLOCK_ERASE_CYCLES(110),
    .CHIP_ERASE_CYCLES(120)) DUT (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .spi_cs_n_in(spi_cs_n_in), .spi_sck_in(spi_sck_in),
    .spi_si_in(spi_si_in), .array_protect_bit_in(array_protect_bit_in),
    .erase_fail_in(erase_fail_in),
    .write_enable_latch_out(write_enable_latch_out), .busy_out(busy_out),
    .erase_program_error_flag_out(erase_program_error_flag_out),
    .erase_start_out(erase_start_out), .erase_kind_out(erase_kind_out),
    .page_select_bits_out(page_select_bits_out),
    .block_select_out(block_select_out), .erase_done_out(erase_done_out));
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      fails++;
      $display("ERROR %0t: run timed out", $time);
      conclude;
    end
  end
  task automatic run(input logic [7:0] op, input int n, input bit prot);
    logic [23:0] a;
    logic fail;
    int kind, w;
    bit go, full;
    a = $random(seed);
    fail = $random(seed);
    kind = op == 8'h81 ? 1 : op == 8'h20 ? 2 : op inside {8'h52, 8'hD8} ? 3
      : op inside {8'h60, 8'h62, 8'hC7} ? 4 : op == 8'h06 ? 5
      : op == 8'h04 ? 6 : 0;
    @(posedge clk_in);
    array_protect_bit_in <= prot;
    erase_fail_in <= fail;
    host.frame({op, a, 8'h5A}, n, mode3);
    go = 0;
    full = n >= 8 && n % 8 == 0;
    if (full && kind == 5) m_wel = 1;
    else if (full && kind == 6) m_wel = 0;
    else if (kind inside {[1:4]} && n >= 8)
    begin
      if (!full || n < (kind == 4 ? 8 : 32) || prot) m_wel = 0;
      else if (m_wel)
      begin
        go = 1;
        m_wel = 0;
      end
    end
    repeat (12) @(negedge clk_in);
    `CHK(write_enable_latch_out, m_wel)
    `CHK(busy_out, go)
    if (go)
    begin
      `CHK(erase_kind_out, kind[2:0])
      if (kind == 1) `CHK(page_select_bits_out, a[15:8])
      if (kind == 2) `CHK(block_select_out, {1'b0, a[19:12]})
      if (kind == 3) `CHK(block_select_out, {3'b0, a[20:15]})
      w = 0;
      while (erase_done_out !== 1'b1 && w < 200)
      begin
        @(negedge clk_in);
        w++;
      end
      `CHK(w < 200, 1'b1)
      @(negedge clk_in);
      `CHK(erase_program_error_flag_out, fail)
      @(negedge clk_in);
      `CHK(busy_out, 1'b0)
    end
    $display("test op %h bits %0d done", op, n);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    run(8'h06, 5, 0);
    run(8'h20, 32, 0);
    run(8'h06, 8, 0);
    run(8'h04, 9, 0);
    run(8'h04, 16, 0);
    foreach (ops[i])
    begin
      mode3 = (i > 3);
      run(8'h06, 16, 0);
      run(ops[i], 32 + 8 * (i % 2), 0);
    end
    run(8'h06, 8, 0);
    run(8'h20, 24, 0);
    run(8'h06, 8, 0);
    run(8'h52, 33, 0);
    run(8'h06, 8, 0);
    run(8'hC7, 12, 0);
    run(8'h06, 8, 0);
    run(8'h60, 4, 0);
    run(8'hD8, 32, 1);
    run(8'h06, 8, 0);
    run(8'h81, 32, 1);
    run(8'h06, 8, 0);
    run(8'h62, 16, 1);
    conclude;
  end
endmodule

/* File: common/sfel_consts.vh */
// Constants for the erase and write-enable sequencer.
// Included by the sequencer design file; definitions only.
`ifndef SFEL_CONSTS_VH
`define SFEL_CONSTS_VH
`define SFEL_OP_PAGE_ERASE 8'h81
`define SFEL_OP_BLK4_ERASE 8'h20
`define SFEL_OP_BLK32_ERASE_A 8'h52
`define SFEL_OP_BLK32_ERASE_B 8'hD8
`define SFEL_OP_CHIP_ERASE_A 8'h60
`define SFEL_OP_CHIP_ERASE_B 8'h62
`define SFEL_OP_CHIP_ERASE_C 8'hC7
`define SFEL_OP_WRITE_ENABLE 8'h06
`define SFEL_OP_WRITE_DISABLE 8'h04
`define SFEL_OPCODE_BITS 6'h08
`define SFEL_ADDR_FRAME_BITS 6'h20
`define SFEL_BIT_COUNT_MAX 6'h3F
`define SFEL_BIT_COUNT_WRAP 6'h38
`define SFEL_KIND_NONE 3'h0
`define SFEL_KIND_PAGE 3'h1
`define SFEL_KIND_BLK4 3'h2
`define SFEL_KIND_BLK32 3'h3
`define SFEL_KIND_CHIP 3'h4
`define SFEL_KIND_WREN 3'h5
`define SFEL_KIND_WRDI 3'h6
`define SFEL_PAGE_ERASE_TIME_NS 32'd20000000
`define SFEL_BLOCK_ERASE_TIME_NS 32'd50000000
`define SFEL_CHIP_ERASE_TIME_NS 32'd400000000
`define SFEL_CLK_PERIOD_NS 32'd4
`define SFEL_PAGE_ERASE_CYCLES (`SFEL_PAGE_ERASE_TIME_NS / `SFEL_CLK_PERIOD_NS)
`define SFEL_BLOCK_ERASE_CYCLES (`SFEL_BLOCK_ERASE_TIME_NS / `SFEL_CLK_PERIOD_NS)
`define SFEL_CHIP_ERASE_CYCLES (`SFEL_CHIP_ERASE_TIME_NS / `SFEL_CLK_PERIOD_NS)
`endif

/* File: src/sfel_erase_timer.v */
// Self-timed erase timer: loads a cycle count and runs it down.
// Assumes start_in is a one-cycle pulse that is ignored while busy.
`timescale 1ns/1ps
module sfel_erase_timer #(
  parameter CW = 32
)
(
  input wire clk_in, // Clock
  input wire rst_n_in, // Active-low reset
  input wire start_in, // Start pulse
  input wire [CW-1:0] count_in, // Cycles to run
  output wire busy_out, // Timer running
  output reg done_out // One-cycle pulse at end
);
  reg [CW-1:0] remain;
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      remain <= {CW{1'b0}};
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      if (remain == {CW{1'b0}})
      begin
        if (start_in)
          remain <= count_in;
      end
      else
      begin
        remain <= remain - {{(CW-1){1'b0}}, 1'b1};
        if (remain == {{(CW-1){1'b0}}, 1'b1})
          done_out <= 1'b1;
      end
    end
  end
  assign busy_out = (remain != {CW{1'b0}});
endmodule

/* File: src/sfel_sequencer.v */
// Erase and write-enable command sequencer of an SPI serial flash.
// Assumes SPI pins arrive asynchronously; sampled with two flip-flops.
// Assumes the protect bit is steady from chip-select rise to erase start.
// Behaviour
// [R1] Page erase is 81h, then don't-care, page select, don't-care bytes.
// [R2] Valid page erase starts a self-timed erase at chip-select rise.
// [R3] Busy flag reads busy while a page erase runs.
// [R4] Failed erase verify sets the erase/program error flag.
// [R5] 20h erases 4-Kbyte block; 52h or D8h erase 32-Kbyte block.
// [R6] Erase commands refused unless write enable latch already set.
// [R7] Block erase ignores bits after address; starts on deselect.
// [R8] Block selection ignores A11-A0 (4K) or A14-A0 (32K).
// [R9] Truncated address or off-byte deselect aborts block erase.
// [R10] Protected array: block erase not executed, back to idle.
// [R11] Block erase abort of any kind clears write enable latch.
// [R12] Block erase shows busy; latch cleared before erase ends.
// [R13] 60h, 62h, C7h are identical chip erases without address.
// [R14] Chip erase ignores trailing bits, erases whole array on deselect.
// [R15] Truncated/off-byte/protected chip erase does not erase.
// [R16] Chip erase shows busy; latch cleared before erase ends.
// [R17] 06h sets latch on deselect if frame complete and byte aligned.
// [R18] 04h clears latch on deselect if frame complete and byte aligned.
// [R19] Protect bit set protects whole array; erases ignored.
// [R20] Frame bit counter checked at deselect for length and alignment.
`timescale 1ns/1ps
`include "sfel_consts.vh"
module sfel_sequencer #(
  parameter PAGE_ERASE_CYCLES = `SFEL_PAGE_ERASE_CYCLES,
  parameter BLOCK_ERASE_CYCLES = `SFEL_BLOCK_ERASE_CYCLES,
  parameter CHIP_ERASE_CYCLES = `SFEL_CHIP_ERASE_CYCLES
)
(
  input wire clk_in, // 250 MHz clock
  input wire arst_n_in, // Asynchronous active-low reset
  input wire spi_cs_n_in, // SPI chip select, active low
  input wire spi_sck_in, // SPI clock, modes 0 and 3
  input wire spi_si_in, // SPI serial data in
  input wire array_protect_bit_in, // Whole array protected
  input wire erase_fail_in, // Erase verify failure, level
  output reg write_enable_latch_out, // Write enable latch
  output wire busy_out, // Ready/busy flag, high is busy
  output reg erase_program_error_flag_out, // Erase error flag
  output reg erase_start_out, // Pulse: erase begins
  output reg [2:0] erase_kind_out, // Kind of running erase
  output reg [7:0] page_select_bits_out, // Page being erased
  output reg [8:0] block_select_out, // Block index being erased
  output reg erase_done_out // Pulse: erase finished
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ERASE = 2'h1;
  localparam ST_VERIFY = 2'h2;

  reg rst_meta;
  reg rst_n;
  wire cs_n_s;
  wire sck_s;
  wire si_s;
  wire fail_s;
  reg cs_n_d;
  reg sck_d;
  reg [5:0] bit_count;
  reg [7:0] opcode;
  reg [23:0] addr;
  reg [1:0] state;
  reg fail_seen;
  reg timer_start;
  reg [31:0] timer_count;
  wire timer_busy;
  wire timer_done;
  wire sck_rise;
  wire cs_rise;
  wire cs_fall;
  wire [2:0] kind;
  wire aligned;
  wire op_complete;
  reg [2:0] next_kind_run;

  // Classify an opcode into a command kind
  function [2:0] sfel_decode;
    input [7:0] op;
    begin
      case (op)
        `SFEL_OP_PAGE_ERASE: sfel_decode = `SFEL_KIND_PAGE;
        `SFEL_OP_BLK4_ERASE: sfel_decode = `SFEL_KIND_BLK4;
        `SFEL_OP_BLK32_ERASE_A: sfel_decode = `SFEL_KIND_BLK32;
        `SFEL_OP_BLK32_ERASE_B: sfel_decode = `SFEL_KIND_BLK32;
        `SFEL_OP_CHIP_ERASE_A: sfel_decode = `SFEL_KIND_CHIP;
        `SFEL_OP_CHIP_ERASE_B: sfel_decode = `SFEL_KIND_CHIP;
        `SFEL_OP_CHIP_ERASE_C: sfel_decode = `SFEL_KIND_CHIP;
        `SFEL_OP_WRITE_ENABLE: sfel_decode = `SFEL_KIND_WREN;
        `SFEL_OP_WRITE_DISABLE: sfel_decode = `SFEL_KIND_WRDI;
        default: sfel_decode = `SFEL_KIND_NONE;
      endcase
    end
  endfunction

  // Frame length check: byte aligned, and long enough for the kind
  function sfel_length_ok;
    input [2:0] k;
    input [5:0] count;
    begin
      if ((count[2:0] != 3'h0) || (count == 6'h00))
        sfel_length_ok = 1'b0; // [R20]
      else
      begin
        case (k)
          `SFEL_KIND_PAGE, `SFEL_KIND_BLK4, `SFEL_KIND_BLK32:
            sfel_length_ok = (count >= `SFEL_ADDR_FRAME_BITS); // [R9]
          default:
            sfel_length_ok = (count >= `SFEL_OPCODE_BITS);
        endcase
      end
    end
  endfunction

  // Reset release through two flip-flops
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  sfel_sync2 #(.RESET_VALUE(1'b1)) u_sync_cs (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .d_in(spi_cs_n_in),
    .q_out(cs_n_s)
  );
  sfel_sync2 #(.RESET_VALUE(1'b0)) u_sync_sck (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .d_in(spi_sck_in),
    .q_out(sck_s)
  );
  sfel_sync2 #(.RESET_VALUE(1'b0)) u_sync_si (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .d_in(spi_si_in),
    .q_out(si_s)
  );
  sfel_sync2 #(.RESET_VALUE(1'b0)) u_sync_fail (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .d_in(erase_fail_in),
    .q_out(fail_s)
  );

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_n_d <= 1'b1;
      sck_d <= 1'b0;
    end
    else
    begin
      cs_n_d <= cs_n_s;
      sck_d <= sck_s;
    end
  end

  // Data sampled on rising SCK, valid for both mode 0 and mode 3
  assign sck_rise = sck_s & ~sck_d & ~cs_n_s;
  assign cs_rise = cs_n_s & ~cs_n_d;
  assign cs_fall = ~cs_n_s & cs_n_d;

  // Bit counter folds back by eight at its top so alignment stays exact
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_count <= 6'h00;
      opcode <= 8'h00;
      addr <= 24'h000000;
    end
    else if (cs_fall)
    begin
      bit_count <= 6'h00;
      opcode <= 8'h00;
      addr <= 24'h000000;
    end
    else if (sck_rise)
    begin
      if (bit_count == `SFEL_BIT_COUNT_MAX)
        bit_count <= `SFEL_BIT_COUNT_WRAP; // [R20]
      else
        bit_count <= bit_count + 6'h01; // [R20]
      if (bit_count < `SFEL_OPCODE_BITS)
        opcode <= {opcode[6:0], si_s};
      else if (bit_count < `SFEL_ADDR_FRAME_BITS)
        addr <= {addr[22:0], si_s};
      // Later bits are dropped [R7] [R14]
    end
  end

  assign kind = sfel_decode(opcode);
  assign aligned = (bit_count[2:0] == 3'h0) && (bit_count != 6'h00); // [R20]
  assign op_complete = (bit_count >= `SFEL_OPCODE_BITS);

  // Erase duration per kind
  always @*
  begin
    next_kind_run = kind;
    case (kind)
      `SFEL_KIND_PAGE: timer_count = PAGE_ERASE_CYCLES;
      `SFEL_KIND_BLK4: timer_count = BLOCK_ERASE_CYCLES;
      `SFEL_KIND_BLK32: timer_count = BLOCK_ERASE_CYCLES;
      `SFEL_KIND_CHIP: timer_count = CHIP_ERASE_CYCLES;
      default: timer_count = 32'h00000001;
    endcase
  end

  sfel_erase_timer #(.CW(32)) u_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .start_in(timer_start),
    .count_in(timer_count),
    .busy_out(timer_busy),
    .done_out(timer_done)
  );

  // Busy from the start decision until verify completes [R3] [R12] [R16]
  assign busy_out = (state != ST_IDLE);

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      write_enable_latch_out <= 1'b0;
      erase_program_error_flag_out <= 1'b0;
      erase_start_out <= 1'b0;
      erase_kind_out <= `SFEL_KIND_NONE;
      page_select_bits_out <= 8'h00;
      block_select_out <= 9'h000;
      erase_done_out <= 1'b0;
      timer_start <= 1'b0;
      fail_seen <= 1'b0;
    end
    else
    begin
      erase_start_out <= 1'b0;
      erase_done_out <= 1'b0;
      timer_start <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (cs_rise)
          begin
            case (kind)
              `SFEL_KIND_WREN:
                if (sfel_length_ok(kind, bit_count))
                  write_enable_latch_out <= 1'b1; // [R17]
              `SFEL_KIND_WRDI:
                if (sfel_length_ok(kind, bit_count))
                  write_enable_latch_out <= 1'b0; // [R18]
              `SFEL_KIND_PAGE, `SFEL_KIND_BLK4, `SFEL_KIND_BLK32:
              begin
                // A cut opcode can look like a shorter erase code
                if (!op_complete)
                  state <= ST_IDLE;
                else if (!sfel_length_ok(kind, bit_count) ||
                  array_protect_bit_in)
                  write_enable_latch_out <= 1'b0; // [R9] [R10] [R11] [R19]
                else if (write_enable_latch_out) // [R6]
                begin
                  state <= ST_ERASE; // [R2] [R7]
                  timer_start <= 1'b1;
                  erase_start_out <= 1'b1;
                  erase_kind_out <= next_kind_run; // [R5]
                  fail_seen <= 1'b0;
                  // Only the running kind's select is shown, others zero
                  case (kind)
                    `SFEL_KIND_PAGE:
                    begin
                      page_select_bits_out <= addr[15:8]; // [R1]
                      block_select_out <= 9'h000;
                    end
                    `SFEL_KIND_BLK4:
                    begin
                      page_select_bits_out <= 8'h00;
                      block_select_out <= {1'b0, addr[19:12]}; // [R8]
                    end
                    default:
                    begin
                      page_select_bits_out <= 8'h00;
                      block_select_out <= {3'h0, addr[20:15]}; // [R8]
                    end
                  endcase
                end
              end
              `SFEL_KIND_CHIP:
              begin
                if (op_complete && (!aligned || array_protect_bit_in))
                  write_enable_latch_out <= 1'b0; // [R15] [R19]
                else if (op_complete && write_enable_latch_out) // [R6]
                begin
                  state <= ST_ERASE; // [R13] [R14]
                  timer_start <= 1'b1;
                  erase_start_out <= 1'b1;
                  erase_kind_out <= `SFEL_KIND_CHIP;
                  page_select_bits_out <= 8'h00;
                  block_select_out <= 9'h000;
                  fail_seen <= 1'b0;
                end
              end
              default:
                state <= ST_IDLE;
            endcase
          end
        end
        ST_ERASE:
        begin
          // Frames that end now are ignored; the bit counter still runs
          // Latch drops as the erase gets under way [R12] [R16]
          write_enable_latch_out <= 1'b0;
          if (fail_s)
            fail_seen <= 1'b1;
          if (timer_done)
            state <= ST_VERIFY;
        end
        ST_VERIFY:
        begin
          if (fail_seen || fail_s)
            erase_program_error_flag_out <= 1'b1; // [R4]
          else
            erase_program_error_flag_out <= 1'b0;
          erase_done_out <= 1'b1;
          erase_kind_out <= `SFEL_KIND_NONE;
          state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule

/* File: src/sfel_sync2.v */
// Two-flip-flop synchroniser for one level from outside the clock domain.
// Assumes the reset given is already synchronous to clk_in on release.
`timescale 1ns/1ps
module sfel_sync2 #(
  parameter RESET_VALUE = 1'b0
)
(
  input wire clk_in, // Domain clock
  input wire rst_n_in, // Active-low reset
  input wire d_in, // Asynchronous level
  output wire q_out // Synchronised level
);
  reg stage1;
  reg stage2;
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
    end
    else
    begin
      stage1 <= d_in;
      stage2 <= stage1;
    end
  end
  assign q_out = stage2;
endmodule
